// [rtl/pvfm_calc_if.sv]
// signals between the forwarding block and its mask combiner
interface pvfm_calc_if #(
  parameter int NPORT = pvfm_pkg::NUM_PORTS
);
  logic [NPORT-1:0]          vlan_mask;
  logic [NPORT-1:0]          group_mask;
  logic [NPORT-1:0]          iso_mask;
  logic [pvfm_pkg::SRC_W-1:0] src_port;
  logic [NPORT-1:0]          egress;

  modport calc (
    input  vlan_mask,
    input  group_mask,
    input  iso_mask,
    input  src_port,
    output egress
  );
  modport user (
    output vlan_mask,
    output group_mask,
    output iso_mask,
    output src_port,
    input  egress
  );
endinterface : pvfm_calc_if

// [rtl/pvfm_forward_mask.sv]
// private vlan forwarding mask: tables, lookup and register port
//
// The register offsets and the plain strobed port are this design's own decisions.
module pvfm_forward_mask #(
  parameter int NPORT = pvfm_pkg::NUM_PORTS,
  parameter int NVLAN = pvfm_pkg::NUM_VLAN_ENTRIES,
  parameter int NGRP  = pvfm_pkg::NUM_GROUPS
) (
  input  wire logic                          clock_i,
  input  wire logic                          rstn_i,
  input  wire logic [pvfm_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [pvfm_pkg::DATA_W-1:0]   reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [pvfm_pkg::DATA_W-1:0]   reg_rdata_o,
  input  wire logic                          frame_valid_i,
  input  wire logic [pvfm_pkg::SRC_W-1:0]    frame_src_i,
  input  wire logic                          frame_tagged_i,
  input  wire logic [pvfm_pkg::VID_W-1:0]    frame_vid_i,
  output logic                               fwd_valid_o,
  output logic      [NPORT-1:0]              fwd_mask_o,
  output logic      [NPORT-1:0]              fwd_untag_mask_o,
  output logic      [NPORT-1:0]              fwd_tag_mask_o,
  output logic      [pvfm_pkg::VID_W-1:0]    fwd_vid_o
);
  localparam int VW = pvfm_pkg::VID_W;
  localparam int DW = pvfm_pkg::DATA_W;

  // configuration state
  logic [NPORT-1:0] iso_q,       iso_d;
  logic [VW-1:0]    port_default_vlan_id_q       [NPORT];
  logic [VW-1:0]    port_default_vlan_id_d       [NPORT];
  logic             vl_valid_q   [NVLAN];
  logic             vl_valid_d   [NVLAN];
  logic [VW-1:0]    vl_vid_q     [NVLAN];
  logic [VW-1:0]    vl_vid_d     [NVLAN];
  logic [NPORT-1:0] vl_member_q  [NVLAN];
  logic [NPORT-1:0] vl_member_d  [NVLAN];
  logic [NPORT-1:0] vl_untag_q   [NVLAN];
  logic [NPORT-1:0] vl_untag_d   [NVLAN];
  logic [NPORT-1:0] grp_q        [NGRP];
  logic [NPORT-1:0] grp_d        [NGRP];
  logic             fwd_en_q,    fwd_en_d;

  // status and output state
  logic [DW-1:0]    rdata_q,     rdata_d;
  logic [NPORT-1:0] last_mask_q, last_mask_d;
  logic [DW-1:0]    frame_cnt_q, frame_cnt_d;
  logic [DW-1:0]    drop_cnt_q,  drop_cnt_d;
  logic             valid_q,     valid_d;
  logic [NPORT-1:0] mask_q,      mask_d;
  logic [NPORT-1:0] untag_q,     untag_d;
  logic [NPORT-1:0] tag_q,       tag_d;
  logic [VW-1:0]    vid_q,       vid_d;

  // lookup results
  logic             src_ok;
  logic [VW-1:0]    eff_vid;
  logic             vl_hit;
  logic [NPORT-1:0] vl_member;
  logic [NPORT-1:0] vl_untag;
  logic [NPORT-1:0] grp_mask;
  logic             clr_cnt;
  logic [NPORT-1:0] src_sel;
  logic [NVLAN-1:0] vl_match;
  logic [NGRP-1:0]  grp_hit;

  pvfm_calc_if #(.NPORT(NPORT)) calc_bus ();

  pvfm_mask_calc #(
    .NPORT (NPORT)
  ) u_calc (
    .c (calc_bus.calc)
  );

  // ingress vid from the tag or the port default
  always_comb begin
    eff_vid = frame_vid_i;
    if (!frame_tagged_i) begin
      eff_vid = '0;
      for (int p = 0; p < NPORT; p++) begin
        if (frame_src_i == pvfm_pkg::SRC_W'(p)) begin
          eff_vid = port_default_vlan_id_q[p];
        end
      end
    end
  end

  // per-port source select, per-entry vid match, per-group source membership
  for (genvar p = 0; p < NPORT; p++) begin : g_src_sel
    assign src_sel[p] = (frame_src_i == pvfm_pkg::SRC_W'(p));
  end
  for (genvar i = 0; i < NVLAN; i++) begin : g_vl_match
    assign vl_match[i] = vl_valid_q[i] && (vl_vid_q[i] == eff_vid);
  end
  for (genvar g = 0; g < NGRP; g++) begin : g_grp_hit
    assign grp_hit[g] = |(grp_q[g] & src_sel);
  end

  // vlan lookup and source group mask
  always_comb begin
    src_ok    = (frame_src_i < pvfm_pkg::SRC_W'(NPORT));
    vl_hit    = 1'b0;
    vl_member = '0;
    vl_untag  = '0;
    grp_mask  = '0;
    for (int i = 0; i < NVLAN; i++) begin
      if (!vl_hit && vl_match[i]) begin
        vl_hit    = 1'b1;
        vl_member = vl_member_q[i];
        vl_untag  = vl_untag_q[i];
      end
    end
    for (int g = 0; g < NGRP; g++) begin
      if (grp_hit[g]) begin
        grp_mask = grp_mask | grp_q[g];
      end
    end
  end

  assign calc_bus.vlan_mask  = vl_member;
  assign calc_bus.group_mask = grp_mask;
  assign calc_bus.iso_mask   = iso_q;
  assign calc_bus.src_port   = frame_src_i;

  // forwarding result and counters
  always_comb begin
    valid_d     = frame_valid_i;
    mask_d      = '0;
    untag_d     = '0;
    tag_d       = '0;
    vid_d       = vid_q;
    last_mask_d = last_mask_q;
    frame_cnt_d = frame_cnt_q;
    drop_cnt_d  = drop_cnt_q;
    if (frame_valid_i) begin
      vid_d       = eff_vid;
      frame_cnt_d = frame_cnt_q + 32'h00000001;
      if (src_ok && vl_hit && fwd_en_q) begin
        mask_d  = calc_bus.egress;
        untag_d = calc_bus.egress & vl_untag;
        tag_d   = calc_bus.egress & ~vl_untag;
      end
      last_mask_d = mask_d;
      if (mask_d == '0) begin
        drop_cnt_d = drop_cnt_q + 32'h00000001;
      end
    end
    if (clr_cnt) begin
      frame_cnt_d = '0;
      drop_cnt_d  = '0;
    end
  end

  // register writes
  always_comb begin
    iso_d    = iso_q;
    fwd_en_d = fwd_en_q;
    clr_cnt  = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      port_default_vlan_id_d[p] = port_default_vlan_id_q[p];
    end
    for (int i = 0; i < NVLAN; i++) begin
      vl_valid_d[i]  = vl_valid_q[i];
      vl_vid_d[i]    = vl_vid_q[i];
      vl_member_d[i] = vl_member_q[i];
      vl_untag_d[i]  = vl_untag_q[i];
    end
    for (int g = 0; g < NGRP; g++) begin
      grp_d[g] = grp_q[g];
    end
    if (reg_wr_i) begin
      if (reg_addr_i == pvfm_pkg::ADDR_ISOLATE) begin
        iso_d = reg_wdata_i[NPORT-1:0];
      end else if (reg_addr_i == pvfm_pkg::ADDR_CONTROL) begin
        fwd_en_d = reg_wdata_i[pvfm_pkg::CTRL_EN_BIT];
        clr_cnt  = reg_wdata_i[pvfm_pkg::CTRL_CLR_BIT];
      end
      for (int p = 0; p < NPORT; p++) begin
        if (reg_addr_i == pvfm_pkg::ADDR_PORT_DEFAULT_VLAN_ID_BASE + pvfm_pkg::ADDR_W'(p)) begin
          port_default_vlan_id_d[p] = reg_wdata_i[VW-1:0];
        end
      end
      for (int i = 0; i < NVLAN; i++) begin
        if (reg_addr_i == pvfm_pkg::ADDR_VLAN_BASE
            + pvfm_pkg::ADDR_W'(i * pvfm_pkg::VLAN_STRIDE + pvfm_pkg::VLAN_OFS_VID)) begin
          vl_valid_d[i] = reg_wdata_i[pvfm_pkg::VLAN_VALID_BIT];
          vl_vid_d[i]   = reg_wdata_i[VW-1:0];
        end else if (reg_addr_i == pvfm_pkg::ADDR_VLAN_BASE
            + pvfm_pkg::ADDR_W'(i * pvfm_pkg::VLAN_STRIDE + pvfm_pkg::VLAN_OFS_MEMBER)) begin
          vl_member_d[i] = reg_wdata_i[NPORT-1:0];
        end else if (reg_addr_i == pvfm_pkg::ADDR_VLAN_BASE
            + pvfm_pkg::ADDR_W'(i * pvfm_pkg::VLAN_STRIDE + pvfm_pkg::VLAN_OFS_UNTAG)) begin
          vl_untag_d[i] = reg_wdata_i[NPORT-1:0];
        end
      end
      for (int g = 0; g < NGRP; g++) begin
        if (reg_addr_i == pvfm_pkg::ADDR_GROUP_BASE + pvfm_pkg::ADDR_W'(g)) begin
          grp_d[g] = reg_wdata_i[NPORT-1:0];
        end
      end
    end
  end

  // register reads, data valid one cycle after the strobe only
  always_comb begin
    rdata_d = '0;
    if (reg_rd_i) begin
      if (reg_addr_i == pvfm_pkg::ADDR_ISOLATE) begin
        rdata_d[NPORT-1:0] = iso_q;
      end else if (reg_addr_i == pvfm_pkg::ADDR_LAST_MASK) begin
        rdata_d[NPORT-1:0] = last_mask_q;
      end else if (reg_addr_i == pvfm_pkg::ADDR_FRAME_CNT) begin
        rdata_d = frame_cnt_q;
      end else if (reg_addr_i == pvfm_pkg::ADDR_DROP_CNT) begin
        rdata_d = drop_cnt_q;
      end else if (reg_addr_i == pvfm_pkg::ADDR_CONTROL) begin
        rdata_d[pvfm_pkg::CTRL_EN_BIT] = fwd_en_q;
      end
      for (int p = 0; p < NPORT; p++) begin
        if (reg_addr_i == pvfm_pkg::ADDR_PORT_DEFAULT_VLAN_ID_BASE + pvfm_pkg::ADDR_W'(p)) begin
          rdata_d[VW-1:0] = port_default_vlan_id_q[p];
        end
      end
      for (int i = 0; i < NVLAN; i++) begin
        if (reg_addr_i == pvfm_pkg::ADDR_VLAN_BASE
            + pvfm_pkg::ADDR_W'(i * pvfm_pkg::VLAN_STRIDE + pvfm_pkg::VLAN_OFS_VID)) begin
          rdata_d[pvfm_pkg::VLAN_VALID_BIT] = vl_valid_q[i];
          rdata_d[VW-1:0]                   = vl_vid_q[i];
        end else if (reg_addr_i == pvfm_pkg::ADDR_VLAN_BASE
            + pvfm_pkg::ADDR_W'(i * pvfm_pkg::VLAN_STRIDE + pvfm_pkg::VLAN_OFS_MEMBER)) begin
          rdata_d[NPORT-1:0] = vl_member_q[i];
        end else if (reg_addr_i == pvfm_pkg::ADDR_VLAN_BASE
            + pvfm_pkg::ADDR_W'(i * pvfm_pkg::VLAN_STRIDE + pvfm_pkg::VLAN_OFS_UNTAG)) begin
          rdata_d[NPORT-1:0] = vl_untag_q[i];
        end
      end
      for (int g = 0; g < NGRP; g++) begin
        if (reg_addr_i == pvfm_pkg::ADDR_GROUP_BASE + pvfm_pkg::ADDR_W'(g)) begin
          rdata_d[NPORT-1:0] = grp_q[g];
        end
      end
    end
  end

  // configuration registers
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      iso_q    <= pvfm_pkg::RST_ISOLATE[NPORT-1:0];
      fwd_en_q <= pvfm_pkg::RST_FWD_ENABLE;
      for (int p = 0; p < NPORT; p++) begin
        port_default_vlan_id_q[p] <= pvfm_pkg::RST_PORT_DEFAULT_VLAN_ID;
      end
      for (int i = 0; i < NVLAN; i++) begin
        vl_valid_q[i]  <= (i == 0);
        vl_vid_q[i]    <= (i == 0) ? pvfm_pkg::RST_VLAN0_VID : '0;
        vl_member_q[i] <= (i == 0) ? pvfm_pkg::RST_ALL_PORTS[NPORT-1:0] : '0;
        vl_untag_q[i]  <= (i == 0) ? pvfm_pkg::RST_ALL_PORTS[NPORT-1:0] : '0;
      end
      for (int g = 0; g < NGRP; g++) begin
        grp_q[g] <= (g == 0) ? pvfm_pkg::RST_ALL_PORTS[NPORT-1:0] : '0;
      end
    end else begin
      iso_q    <= iso_d;
      fwd_en_q <= fwd_en_d;
      port_default_vlan_id_q   <= port_default_vlan_id_d;
      vl_valid_q  <= vl_valid_d;
      vl_vid_q    <= vl_vid_d;
      vl_member_q <= vl_member_d;
      vl_untag_q  <= vl_untag_d;
      grp_q       <= grp_d;
    end
  end

  // status and output registers
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_q     <= '0;
      last_mask_q <= '0;
      frame_cnt_q <= '0;
      drop_cnt_q  <= '0;
      valid_q     <= 1'b0;
      mask_q      <= '0;
      untag_q     <= '0;
      tag_q       <= '0;
      vid_q       <= '0;
    end else begin
      rdata_q     <= rdata_d;
      last_mask_q <= last_mask_d;
      frame_cnt_q <= frame_cnt_d;
      drop_cnt_q  <= drop_cnt_d;
      valid_q     <= valid_d;
      mask_q      <= mask_d;
      untag_q     <= untag_d;
      tag_q       <= tag_d;
      vid_q       <= vid_d;
    end
  end

  assign reg_rdata_o      = rdata_q;
  assign fwd_valid_o      = valid_q;
  assign fwd_mask_o       = mask_q;
  assign fwd_untag_mask_o = untag_q;
  assign fwd_tag_mask_o   = tag_q;
  assign fwd_vid_o        = vid_q;

endmodule : pvfm_forward_mask

// [rtl/pvfm_mask_calc.sv]
// combines vlan, source group and isolation masks into the egress set
module pvfm_mask_calc #(
  parameter int NPORT = pvfm_pkg::NUM_PORTS
) (
  pvfm_calc_if.calc c
);
  logic [NPORT-1:0] src_onehot;
  logic             src_isolated;

  always_comb begin
    src_onehot   = '0;
    src_isolated = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      if (c.src_port == pvfm_pkg::SRC_W'(p)) begin
        src_onehot[p] = 1'b1;
        src_isolated  = c.iso_mask[p];
      end
    end
    c.egress = c.vlan_mask & c.group_mask & ~src_onehot;
    if (src_isolated) begin
      c.egress = c.egress & ~c.iso_mask;
    end
  end
endmodule : pvfm_mask_calc

// [rtl/pvfm_pkg.sv]
// constants and register map of the private vlan forwarding mask block
//
// Summary of operation
// - a frame entering on a promiscuous port is limited by the vlan table member mask and the source group mask.
// - a frame entering on an isolated port is limited by source group and vlan masks to promiscuous ports.
// - an isolated port only receives frames sent from promiscuous ports of the same source group.
// - a promiscuous port may receive from every member of its source group, isolated or not.
// - there is one isolation bit per port, shared by all source groups that port is in.
// - after reset every isolation bit is clear, so all ports are promiscuous.
// - there are 24 isolation bits, a set bit meaning isolated and a clear bit promiscuous.
// - an untagged frame takes the port_default_vlan_id of its ingress port, vlan 1 after reset.
// - an egress port that is an untagged member of the frame's vlan sends it without a tag.
// - an egress port that is a tagged member of the frame's vlan sends it with the tag kept.
// - a frame goes only to members of its own vlan.
// - an egress port must be in the frame's vlan and in a source_port_group of the source.
// - the source group mask comes from the source port, with group ids apart from vlan ids.
package pvfm_pkg;

  localparam int NUM_PORTS        = 24;
  localparam int NUM_VLAN_ENTRIES = 8;
  localparam int NUM_GROUPS       = 24;
  localparam int VID_W            = 12;
  localparam int SRC_W            = 5;
  localparam int ADDR_W           = 8;
  localparam int DATA_W           = 32;

  // register map, one word per address
  localparam logic [7:0] ADDR_ISOLATE    = 8'h00;
  localparam logic [7:0] ADDR_LAST_MASK  = 8'h01;
  localparam logic [7:0] ADDR_FRAME_CNT  = 8'h02;
  localparam logic [7:0] ADDR_DROP_CNT   = 8'h03;
  localparam logic [7:0] ADDR_CONTROL    = 8'h04;
  localparam logic [7:0] ADDR_PORT_DEFAULT_VLAN_ID_BASE  = 8'h10;
  localparam logic [7:0] ADDR_VLAN_BASE  = 8'h40;
  localparam logic [7:0] ADDR_GROUP_BASE = 8'h80;
  localparam int         VLAN_STRIDE     = 4;
  localparam int         VLAN_OFS_VID    = 0;
  localparam int         VLAN_OFS_MEMBER = 1;
  localparam int         VLAN_OFS_UNTAG  = 2;

  // field positions
  localparam int VLAN_VALID_BIT = 16;
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_CLR_BIT   = 1;

  // reset values
  localparam logic [23:0] RST_ISOLATE     = 24'h000000;
  localparam logic [11:0] RST_PORT_DEFAULT_VLAN_ID        = 12'h001;
  localparam logic [11:0] RST_VLAN0_VID   = 12'h001;
  localparam logic [23:0] RST_ALL_PORTS   = 24'hFFFFFF;
  localparam logic        RST_FWD_ENABLE  = 1'b1;

endpackage : pvfm_pkg

// [tb/pvfm_assertions.sv]
// port checker for the forwarding mask block
module pvfm_checker #(
  parameter int NPORT = pvfm_pkg::NUM_PORTS
) (
  input wire logic             clock_i,
  input wire logic             rstn_i,
  input wire logic [7:0]       reg_addr_i,
  input wire logic [31:0]      reg_wdata_i,
  input wire logic             reg_wr_i,
  input wire logic             reg_rd_i,
  input wire logic [31:0]      reg_rdata_o,
  input wire logic             frame_valid_i,
  input wire logic [4:0]       frame_src_i,
  input wire logic             frame_tagged_i,
  input wire logic [11:0]      frame_vid_i,
  input wire logic             fwd_valid_o,
  input wire logic [NPORT-1:0] fwd_mask_o,
  input wire logic [NPORT-1:0] fwd_untag_mask_o,
  input wire logic [NPORT-1:0] fwd_tag_mask_o,
  input wire logic [11:0]      fwd_vid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  logic [NPORT-1:0] iso_q;
  logic [NPORT-1:0] iso_d;
  // shadow of the isolation register
  always_comb begin
    iso_d = iso_q;
    if (reg_wr_i && reg_addr_i == pvfm_pkg::ADDR_ISOLATE) iso_d = reg_wdata_i[NPORT-1:0];
  end
  always_ff @(posedge clock_i) begin
    if (!rstn_i) iso_q <= {NPORT{1'b0}};
    else iso_q <= iso_d;
  end
  answer_follows_a: assert property (frame_valid_i |=> fwd_valid_o)
    else $error("lookup answer missing");
  no_spurious_a: assert property (!frame_valid_i |=> !fwd_valid_o)
    else $error("answer without request");
  idle_mask_a: assert property (!fwd_valid_o |-> fwd_mask_o == {NPORT{1'b0}})
    else $error("mask set while idle");
  source_excluded_a: assert property (frame_valid_i && frame_src_i < 5'h18
    |=> fwd_mask_o[$past(frame_src_i)] == 1'b0) else $error("ingress port in egress set");
  tag_split_a: assert property (fwd_valid_o |-> (fwd_untag_mask_o | fwd_tag_mask_o) ==
    fwd_mask_o && (fwd_untag_mask_o & fwd_tag_mask_o) == {NPORT{1'b0}})
    else $error("tag split wrong");
  tagged_vid_a: assert property (frame_valid_i && frame_tagged_i
    |=> fwd_vid_o == $past(frame_vid_i)) else $error("tagged vid changed");
  isolated_guard_a: assert property (frame_valid_i && frame_src_i < 5'h18
    && iso_q[frame_src_i] |=> (fwd_mask_o & $past(iso_q)) == {NPORT{1'b0}})
    else $error("isolated reached isolated");
  bad_source_a: assert property (frame_valid_i && frame_src_i > 5'h17
    |=> fwd_mask_o == {NPORT{1'b0}}) else $error("bad source forwarded");
  read_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data without read");
endmodule : pvfm_checker

bind pvfm_forward_mask pvfm_checker #(.NPORT(NPORT)) chk (.clock_i, .rstn_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .frame_valid_i, .frame_src_i,
  .frame_tagged_i, .frame_vid_i, .fwd_valid_o, .fwd_mask_o, .fwd_untag_mask_o,
  .fwd_tag_mask_o, .fwd_vid_o);

// [tb/pvfm_station.sv]
// model of the stations sending frames into the ports
module pvfm_station (
  input  wire logic        clock_i,
  output logic             frame_valid_o,
  output logic [4:0]       frame_src_o,
  output logic             frame_tagged_o,
  output logic [11:0]      frame_vid_o,
  input  wire logic        fwd_valid_i,
  input  wire logic [23:0] fwd_mask_i,
  input  wire logic [23:0] fwd_untag_i,
  input  wire logic [23:0] fwd_tag_i,
  input  wire logic [11:0] fwd_vid_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    frame_valid_o  = 1'b0;
    frame_src_o    = 5'h00;
    frame_tagged_o = 1'b0;
    frame_vid_o    = 12'h000;
  end
  task automatic send(input logic [4:0] s, input logic tg, input logic [11:0] vd,
                      output logic ok, output logic [23:0] m, output logic [23:0] u,
                      output logic [23:0] t, output logic [11:0] v);
    @(posedge clock_i);
    frame_valid_o  <= 1'b1;
    frame_src_o    <= s;
    frame_tagged_o <= tg;
    frame_vid_o    <= vd;
    @(posedge clock_i);
    // released lines show the inverse of the last value
    frame_valid_o  <= 1'b0;
    frame_src_o    <= ~s;
    frame_tagged_o <= ~tg;
    frame_vid_o    <= ~vd;
    #1;
    ok = fwd_valid_i;
    m  = fwd_mask_i;
    u  = fwd_untag_i;
    t  = fwd_tag_i;
    v  = fwd_vid_i;
  endtask : send
endmodule : pvfm_station

// [tb/tb_top.sv]
// self-checking bench of the forwarding mask block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i, rstn_i, reg_wr_i, reg_rd_i, fv, tg, fwd_valid;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, rv;
  logic [4:0]  src;
  logic [11:0] vid, fvid;
  logic [23:0] fmask, funtag, ftag;
  int          fails, total_checks, cycles;

  pvfm_forward_mask uut (.clock_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .frame_valid_i(fv), .frame_src_i(src), .frame_tagged_i(tg),
    .frame_vid_i(vid), .fwd_valid_o(fwd_valid), .fwd_mask_o(fmask),
    .fwd_untag_mask_o(funtag), .fwd_tag_mask_o(ftag), .fwd_vid_o(fvid));
  pvfm_station st (.clock_i, .frame_valid_o(fv), .frame_src_o(src), .frame_tagged_o(tg),
    .frame_vid_o(vid), .fwd_valid_i(fwd_valid), .fwd_mask_i(fmask), .fwd_untag_i(funtag),
    .fwd_tag_i(ftag), .fwd_vid_i(fvid));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : rd
  task automatic frame(input logic [4:0] s, input logic t, input logic [11:0] v,
                       input logic [23:0] em, input logic [23:0] eu, input logic [23:0] et,
                       input logic [11:0] ev);
    logic ok;
    logic [23:0] m, u, g;
    logic [11:0] o;
    st.send(s, t, v, ok, m, u, g, o);
    check({31'h0, ok}, 32'h1);
    check({8'h0, m}, {8'h0, em});
    check({8'h0, u}, {8'h0, eu});
    check({8'h0, g}, {8'h0, et});
    check({20'h0, o}, {20'h0, ev});
  endtask : frame
  task automatic t_reset_state;
    rd(pvfm_pkg::ADDR_ISOLATE, rv);
    check(rv, 32'h0);
    rd(8'hFF, rv);
    check(rv, 32'h0);
    frame(5'h00, 1'b0, 12'h000, 24'hFFFFFE, 24'hFFFFFE, 24'h0, 12'h001);
    frame(5'h17, 1'b1, 12'h001, 24'h7FFFFF, 24'h7FFFFF, 24'h0, 12'h001);
    frame(5'h1F, 1'b1, 12'h001, 24'h0, 24'h0, 24'h0, 12'h001);
  endtask : t_reset_state
  task automatic t_separate_vlans;
    wr(8'h44, 32'h00010002);
    wr(8'h45, 32'h00000007);
    wr(8'h46, 32'h00000003);
    wr(8'h48, 32'h00010003);
    wr(8'h49, 32'h00000038);
    wr(8'h4A, 32'h00000018);
    for (int p = 0; p < 6; p++) wr(pvfm_pkg::ADDR_PORT_DEFAULT_VLAN_ID_BASE + 8'(p), p < 3 ? 32'h2 : 32'h3);
    frame(5'h00, 1'b0, 12'h000, 24'h000006, 24'h000002, 24'h000004, 12'h002);
    frame(5'h02, 1'b1, 12'h002, 24'h000003, 24'h000003, 24'h0, 12'h002);
    frame(5'h03, 1'b0, 12'h000, 24'h000030, 24'h000010, 24'h000020, 12'h003);
    frame(5'h00, 1'b1, 12'h005, 24'h0, 24'h0, 24'h0, 12'h005);
  endtask : t_separate_vlans
  task automatic t_isolation;
    // groups first, then isolation
    wr(8'h80, 32'h0000000F);
    wr(8'h81, 32'h000000F0);
    wr(8'h82, 32'h00000042);
    wr(pvfm_pkg::ADDR_ISOLATE, 32'h00000006);
    rd(pvfm_pkg::ADDR_ISOLATE, rv);
    check(rv, 32'h6);
    frame(5'h00, 1'b1, 12'h001, 24'h00000E, 24'h00000E, 24'h0, 12'h001);
    frame(5'h01, 1'b1, 12'h001, 24'h000049, 24'h000049, 24'h0, 12'h001);
    frame(5'h05, 1'b1, 12'h001, 24'h0000D0, 24'h0000D0, 24'h0, 12'h001);
    frame(5'h06, 1'b1, 12'h001, 24'h0000B2, 24'h0000B2, 24'h0, 12'h001);
    wr(pvfm_pkg::ADDR_ISOLATE, 32'h00000046);
    frame(5'h06, 1'b1, 12'h001, 24'h0000B0, 24'h0000B0, 24'h0, 12'h001);
    frame(5'h01, 1'b1, 12'h001, 24'h000009, 24'h000009, 24'h0, 12'h001);
  endtask : t_isolation
  task automatic t_control;
    rd(pvfm_pkg::ADDR_LAST_MASK, rv);
    check(rv, 32'h00000009);
    rd(pvfm_pkg::ADDR_FRAME_CNT, rv);
    check(rv, 32'h0000000D);
    rd(pvfm_pkg::ADDR_DROP_CNT, rv);
    check(rv, 32'h00000002);
    rd(8'h44, rv);
    check(rv, 32'h00010002);
    rd(8'h82, rv);
    check(rv, 32'h00000042);
    rd(pvfm_pkg::ADDR_PORT_DEFAULT_VLAN_ID_BASE, rv);
    check(rv, 32'h00000002);
    wr(pvfm_pkg::ADDR_CONTROL, 32'h00000000);
    frame(5'h00, 1'b1, 12'h001, 24'h0, 24'h0, 24'h0, 12'h001);
    wr(pvfm_pkg::ADDR_CONTROL, 32'h00000003);
    rd(pvfm_pkg::ADDR_CONTROL, rv);
    check(rv, 32'h00000001);
    rd(pvfm_pkg::ADDR_DROP_CNT, rv);
    check(rv, 32'h00000000);
    frame(5'h00, 1'b1, 12'h001, 24'h00000E, 24'h00000E, 24'h0, 12'h001);
  endtask : t_control
  task automatic t_mid_reset;
    @(posedge clock_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(pvfm_pkg::ADDR_ISOLATE, rv);
    check(rv, 32'h0);
    frame(5'h01, 1'b1, 12'h001, 24'hFFFFFD, 24'hFFFFFD, 24'h0, 12'h001);
  endtask : t_mid_reset
  initial begin
    rstn_i      = 1'b0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 32'h0;
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_reset_state();
    t_separate_vlans();
    t_isolation();
    t_control();
    t_mid_reset();
    close_out();
  end
endmodule : tb_top
